// ---- dps_pkg.sv ----
package dps_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] ADDR_OFS   = 8'h04;
    localparam logic [7:0] WDATA_OFS  = 8'h08;
    localparam logic [7:0] RDATA_OFS  = 8'h0c;
    localparam logic [7:0] STATUS_OFS = 8'h10;

    // Control fields
    localparam int CTRL_OP_LSB  = 0;
    localparam int CTRL_ROLE    = 3;
    localparam int CTRL_START   = 8;
    localparam int CTRL_ABORT   = 9;

    // Status fields
    localparam int ST_ACTIVE    = 0;
    localparam int ST_DONE      = 1;
    localparam int ST_BUSY_SEEN = 2;
    localparam int ST_TOKEN_BIT = 3;
    localparam int ST_OWNED_LSB = 8;

    // Number of token latches and their select width
    localparam int TOKENS       = 8;
    localparam int TOK_AW       = 3;

    // Commands
    typedef enum logic [2:0] {
        DPS_MEM_RD  = 3'h0,
        DPS_MEM_WR  = 3'h1,
        DPS_TOK_ACQ = 3'h2,
        DPS_TOK_REL = 3'h3,
        DPS_TOK_RD  = 3'h4
    } dps_op_t;

    // ------------------------------------------------------------------
    // Timing, ns and derived cycles at pclk
    // ------------------------------------------------------------------
    localparam int CLK_NS                    = 100;
    localparam int MATCH_TO_FLAG_DELAY_NS    = 20;
    localparam int SELECT_TO_FLAG_DELAY_NS   = 20;
    localparam int WRITE_TO_READ_RECOVERY_NS = 10;
    localparam int TOKEN_WRITE_TO_READ_NS    = 10;
    localparam int OUTPUT_ENABLE_ACCESS_NS   = 12;
    localparam int SELECT_ACCESS_NS          = 20;
    localparam int WRITE_PULSE_NS            = 15;
    localparam int SYNC_CYC                  = 3;

    localparam int FLAG_NS = (MATCH_TO_FLAG_DELAY_NS >
        SELECT_TO_FLAG_DELAY_NS) ? MATCH_TO_FLAG_DELAY_NS
        : SELECT_TO_FLAG_DELAY_NS;
    localparam int TOKRD_NS = TOKEN_WRITE_TO_READ_NS
        + OUTPUT_ENABLE_ACCESS_NS;
    localparam int READ_NS = (TOKRD_NS > SELECT_ACCESS_NS) ? TOKRD_NS
        : SELECT_ACCESS_NS;

    // Least times round up, never below one cycle
    localparam int SETTLE_I = (FLAG_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
    localparam int READ_I   = (READ_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
    localparam int PULSE_I  = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECOV_I  = (WRITE_TO_READ_RECOVERY_NS + CLK_NS - 1)
        / CLK_NS;

    localparam logic [7:0] SETTLE_CYC = 8'(SETTLE_I);
    localparam logic [7:0] READ_CYC   = 8'(READ_I);
    localparam logic [7:0] PULSE_CYC  = 8'((PULSE_I < 1) ? 1 : PULSE_I);
    localparam logic [7:0] RECOV_CYC  = 8'((RECOV_I < 1) ? 1 : RECOV_I);
endpackage : dps_pkg

// ---- dps_sync.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Three-flop input synchroniser, output moves when stages 2 and 3 agree
// ----------------------------------------------------------------------
module dps_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin_in,
    output logic      level_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_d;

    // Accept a change only once two late stages agree
    always_comb begin
        lvl_d = (s2_q == s3_q) ? s3_q : level_out;
    end

    // Shift chain and filtered level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q      <= RST_VAL;
            s2_q      <= RST_VAL;
            s3_q      <= RST_VAL;
            level_out <= RST_VAL;
        end else begin
            s1_q      <= pin_in;
            s2_q      <= s1_q;
            s3_q      <= s2_q;
            level_out <= lvl_d;
        end
    end
endmodule : dps_sync

// ---- dps_ctrl.sv ----
`timescale 1ns/1ps
module dps_ctrl #(
    parameter int AW = 15,
    parameter int DW = 8
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    output logic               mem_select_n,
    output logic               token_select_low,
    output logic               rw_n,
    output logic               oe_n,
    output logic [AW-1:0]      addr,
    output logic [DW-1:0]      data_out,
    output logic               data_oe,
    input  wire logic [DW-1:0] data_in,
    input  wire logic          busy_n,
    output logic               role_master
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [DW-1:0] din_s;
    logic          busy_s;

    dps_sync #(.RST_VAL(1'b1)) u_busy (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_in    (busy_n),
        .level_out (busy_s)
    );

    for (genvar i = 0; i < DW; i++) begin : g_din
        dps_sync #(.RST_VAL(1'b0)) u_din (
            .pclk      (pclk),
            .presetn   (presetn),
            .pin_in    (data_in[i]),
            .level_out (din_s[i])
        );
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOV
    } dps_state_t;

    dps_state_t st_q, st_d;
    dps_pkg::dps_op_t op_q, op_d;
    logic [7:0]   cnt_q, cnt_d;
    logic         wr_q, wr_d;
    logic         abort_q, abort_d;
    logic         done_q, done_d;
    logic         bseen_q, bseen_d;
    logic         tokbit_q, tokbit_d;
    logic [dps_pkg::TOKENS-1:0] owned_q, owned_d;
    logic [AW-1:0] addr_q, addr_d;
    logic [DW-1:0] wdat_q, wdat_d;
    logic [DW-1:0] rdat_q, rdat_d;
    logic         role_q, role_d;
    logic         msel_q, msel_d, tsel_q, tsel_d;
    logic         rwn_q, rwn_d, oen_q, oen_d, doe_q, doe_d;
    logic [DW-1:0] dout_q, dout_d;
    logic [31:0]  prd_q, prd_d;
    logic         rdy_q, rdy_d, err_q, err_d;

    logic         tok;
    logic         setup_ph;
    logic         wr_acc;
    logic [2:0]   opf;
    logic [dps_pkg::TOK_AW-1:0] tidx;

    assign tok      = (op_q == dps_pkg::DPS_TOK_ACQ)
                   || (op_q == dps_pkg::DPS_TOK_REL)
                   || (op_q == dps_pkg::DPS_TOK_RD);
    assign setup_ph = psel && !penable;
    assign wr_acc   = setup_ph && pwrite;
    assign opf      = pwdata[dps_pkg::CTRL_OP_LSB +: 3];
    assign tidx     = addr_q[dps_pkg::TOK_AW-1:0];

    // ------------------------------------------------------------------
    // Next-state logic: register file and pin sequencer
    // ------------------------------------------------------------------
    always_comb begin
        st_d     = st_q;
        op_d     = op_q;
        cnt_d    = cnt_q;
        wr_d     = wr_q;
        abort_d  = abort_q;
        done_d   = done_q;
        bseen_d  = bseen_q;
        tokbit_d = tokbit_q;
        owned_d  = owned_q;
        addr_d   = addr_q;
        wdat_d   = wdat_q;
        rdat_d   = rdat_q;
        role_d   = role_q;
        msel_d   = msel_q;
        tsel_d   = tsel_q;
        rwn_d    = rwn_q;
        oen_d    = oen_q;
        doe_d    = doe_q;
        dout_d   = dout_q;
        prd_d    = prd_q;
        rdy_d    = setup_ph;
        err_d    = 1'b0;

        // APB register access, answered in first access cycle
        if (setup_ph) begin
            prd_d = '0;
            unique case (paddr)
                dps_pkg::CTRL_OFS: begin
                    prd_d[dps_pkg::CTRL_OP_LSB +: 3] = op_q;
                    prd_d[dps_pkg::CTRL_ROLE]        = role_q;
                    if (pwrite) begin
                        role_d = pwdata[dps_pkg::CTRL_ROLE];
                        if (pwdata[dps_pkg::CTRL_ABORT]) begin
                            abort_d = 1'b1;
                        end
                        if (pwdata[dps_pkg::CTRL_START] && st_q == ST_IDLE
                            && opf <= dps_pkg::DPS_TOK_RD) begin
                            op_d    = dps_pkg::dps_op_t'(opf);
                            wr_d    = (opf == dps_pkg::DPS_MEM_WR)
                                   || (opf == dps_pkg::DPS_TOK_ACQ)
                                   || (opf == dps_pkg::DPS_TOK_REL);
                            abort_d = 1'b0;
                            done_d  = 1'b0;
                            bseen_d = 1'b0;
                            st_d    = ST_SETUP;
                            cnt_d   = '0;
                        end
                    end
                end
                dps_pkg::ADDR_OFS: begin
                    prd_d[AW-1:0] = addr_q;
                    if (pwrite && st_q == ST_IDLE) begin
                        addr_d = pwdata[AW-1:0];
                    end
                end
                dps_pkg::WDATA_OFS: begin
                    prd_d[DW-1:0] = wdat_q;
                    if (pwrite && st_q == ST_IDLE) begin
                        wdat_d = pwdata[DW-1:0];
                    end
                end
                dps_pkg::RDATA_OFS: prd_d[DW-1:0] = rdat_q;
                dps_pkg::STATUS_OFS: begin
                    prd_d[dps_pkg::ST_ACTIVE]    = (st_q != ST_IDLE);
                    prd_d[dps_pkg::ST_DONE]      = done_q;
                    prd_d[dps_pkg::ST_BUSY_SEEN] = bseen_q;
                    prd_d[dps_pkg::ST_TOKEN_BIT] = tokbit_q;
                    prd_d[dps_pkg::ST_OWNED_LSB +: dps_pkg::TOKENS] = owned_q;
                end
                default: err_d = 1'b1;
            endcase
        end

        // Pin sequencer
        unique case (st_q)
            ST_IDLE: begin
                msel_d = 1'b1;
                tsel_d = 1'b1;
                rwn_d  = 1'b1;
                oen_d  = 1'b1;
                doe_d  = 1'b0;
            end
            ST_SETUP: begin
                msel_d = tok;
                tsel_d = !tok;
                rwn_d  = 1'b1;
                oen_d  = 1'b1;
                doe_d  = wr_q;
                if (op_q == dps_pkg::DPS_TOK_ACQ) begin
                    dout_d = '0;
                end else if (op_q == dps_pkg::DPS_TOK_REL) begin
                    dout_d = {{(DW-1){1'b0}}, 1'b1};
                end else begin
                    dout_d = wdat_q;
                end
                cnt_d = cnt_q + 8'h01;
                // Select pin lands a cycle late, so wait one beyond settle
                if (cnt_q > dps_pkg::SETTLE_CYC) begin
                    cnt_d = '0;
                    if (!tok && !busy_s) begin
                        bseen_d = 1'b1;
                    end else begin
                        st_d  = ST_STROBE;
                        rwn_d = !wr_q;
                        oen_d = wr_q;
                    end
                end
            end
            ST_STROBE: begin
                cnt_d = cnt_q + 8'h01;
                if (cnt_q >= (wr_q ? dps_pkg::PULSE_CYC
                                   : dps_pkg::READ_CYC)) begin
                    cnt_d  = '0;
                    st_d   = ST_RECOV;
                    rwn_d  = 1'b1;
                    oen_d  = 1'b1;
                    msel_d = 1'b1;
                    tsel_d = 1'b1;
                    if (!wr_q) begin
                        rdat_d = din_s;
                        if (tok) begin
                            tokbit_d = din_s[0];
                            owned_d[tidx] = !din_s[0];
                        end
                    end else if (op_q == dps_pkg::DPS_TOK_REL) begin
                        owned_d[tidx] = 1'b0;
                    end
                end
            end
            ST_RECOV: begin
                doe_d = 1'b0;
                cnt_d = cnt_q + 8'h01;
                if (cnt_q >= dps_pkg::RECOV_CYC) begin
                    cnt_d = '0;
                    if (op_q == dps_pkg::DPS_TOK_ACQ && wr_q) begin
                        wr_d = 1'b0;
                        st_d = ST_SETUP;
                    end else if (op_q == dps_pkg::DPS_TOK_ACQ && tokbit_q
                                 && !abort_q) begin
                        st_d = ST_SETUP;
                    end else begin
                        st_d   = ST_IDLE;
                        done_d = 1'b1;
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q     <= ST_IDLE;
            op_q     <= dps_pkg::DPS_MEM_RD;
            cnt_q    <= '0;
            wr_q     <= 1'b0;
            abort_q  <= 1'b0;
            done_q   <= 1'b0;
            bseen_q  <= 1'b0;
            tokbit_q <= 1'b1;
            owned_q  <= '0;
            addr_q   <= '0;
            wdat_q   <= '0;
            rdat_q   <= '0;
            role_q   <= 1'b0;
            msel_q   <= 1'b1;
            tsel_q   <= 1'b1;
            rwn_q    <= 1'b1;
            oen_q    <= 1'b1;
            doe_q    <= 1'b0;
            dout_q   <= '0;
            prd_q    <= '0;
            rdy_q    <= 1'b0;
            err_q    <= 1'b0;
        end else begin
            st_q     <= st_d;
            op_q     <= op_d;
            cnt_q    <= cnt_d;
            wr_q     <= wr_d;
            abort_q  <= abort_d;
            done_q   <= done_d;
            bseen_q  <= bseen_d;
            tokbit_q <= tokbit_d;
            owned_q  <= owned_d;
            addr_q   <= addr_d;
            wdat_q   <= wdat_d;
            rdat_q   <= rdat_d;
            role_q   <= role_d;
            msel_q   <= msel_d;
            tsel_q   <= tsel_d;
            rwn_q    <= rwn_d;
            oen_q    <= oen_d;
            doe_q    <= doe_d;
            dout_q   <= dout_d;
            prd_q    <= prd_d;
            rdy_q    <= rdy_d;
            err_q    <= err_d;
        end
    end

    // Outputs straight from flops
    assign prdata           = prd_q;
    assign pready           = rdy_q;
    assign pslverr          = err_q;
    assign mem_select_n     = msel_q;
    assign token_select_low = tsel_q;
    assign rw_n             = rwn_q;
    assign oe_n             = oen_q;
    assign addr             = addr_q;
    assign data_out         = dout_q;
    assign data_oe          = doe_q;
    assign role_master      = role_q;
endmodule : dps_ctrl

// ---- dps_ctrl_chk.sv ----
`timescale 1ns/1ps
// ------------------------------------------------
// Port checker for the token and memory controller
// ------------------------------------------------
module dps_ctrl_chk #(
    parameter int AW = 15,
    parameter int DW = 8
) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [7:0]    paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic          mem_select_n,
    input wire logic          token_select_low,
    input wire logic          rw_n,
    input wire logic          oe_n,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] data_out,
    input wire logic          data_oe,
    input wire logic [DW-1:0] data_in,
    input wire logic          busy_n,
    input wire logic          role_master
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Strobe shapes on the device pins
    sequence wr_pulse; !rw_n [*2] ##1 rw_n; endsequence
    sequence rd_pulse; !oe_n [*5] ##1 oe_n; endsequence
    sequence no_strobe; (rw_n && oe_n) [*5]; endsequence
    sequence busy_held; (!busy_n && !mem_select_n) [*6]; endsequence

    sel_excl_a: assert property (!(!mem_select_n && !token_select_low))
        else $error("both selects low");
    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    ready_once_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    unmapped_err_a: assert property (psel && !penable && paddr > 8'h10
        |=> pslverr) else $error("no error for unmapped word");
    strobe_sel_a: assert property (!rw_n || !oe_n |->
        !mem_select_n || !token_select_low) else $error("strobe unselected");
    write_drive_a: assert property (!rw_n |-> data_oe && oe_n)
        else $error("write without data drive");
    write_len_a: assert property ($fell(rw_n) |-> wr_pulse)
        else $error("write pulse length wrong");
    read_len_a: assert property ($fell(oe_n) |-> rd_pulse)
        else $error("read strobe length wrong");
    token_setup_a: assert property ($fell(token_select_low)
        |-> no_strobe) else $error("strobe too soon after select");
    token_recov_a: assert property ($rose(token_select_low)
        |-> token_select_low [*2]) else $error("recovery too short");
    busy_hold_a: assert property (busy_held |->
        !$fell(rw_n) && !$fell(oe_n)) else $error("strobe under busy");
endmodule : dps_ctrl_chk

// ---- dps_dev_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------------
// Device model: token latches, small memory, busy
// ------------------------------------------------
module dps_dev_model #(
    parameter int AW = 15,
    parameter int DW = 8
) (
    input  wire logic          pclk,
    input  wire logic          mem_select_n,
    input  wire logic          token_select_low,
    input  wire logic          rw_n,
    input  wire logic          oe_n,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] data_out,
    output logic [DW-1:0]      data_in,
    output logic               busy_n,
    input  wire logic          role_master,
    input  wire logic          force_busy,
    input  wire logic          oth_req,
    input  wire logic          oth_val,
    input  wire logic [2:0]    oth_idx,
    output logic [7:0]         mine
);
    logic [1:0]    own [8];   // 0 free, 1 near port, 2 far port
    logic [7:0]    pend [1:2];
    logic [DW-1:0] mem [16];
    logic          rd_q;
    logic [DW-1:0] last_q;
    logic          wtok_q;
    logic          wmem_q;
    logic [AW-1:0] wadr_q;
    logic [DW-1:0] wdat_q;

    initial begin
        for (int i = 0; i < 8; i++) own[i] = 2'h0;
        pend[1] = 8'h00;
        pend[2] = 8'h00;
        last_q = 8'h00;
        rd_q = 1'b1;
        wtok_q = 1'b0;
        wmem_q = 1'b0;
    end

    // Token write from either side
    task automatic tok_wr(input int s, input int i, input logic v);
        int o;
        o = 3 - s;
        if (!v && own[i] == 2'h0) own[i] = 2'(s);
        else if (!v && own[i] == 2'(o)) pend[s][i] = 1'b1;
        else if (v && own[i] == 2'(s)) begin
            own[i] = pend[o][i] ? 2'(o) : 2'h0;
            pend[o][i] = 1'b0;
        end
        else if (v) pend[s][i] = 1'b0;
    endtask : tok_wr

    // Write cycle state seen before the selects rise with the strobe
    always @(posedge pclk) begin
        if (!rw_n) begin
            wtok_q = !token_select_low && mem_select_n;
            wmem_q = !mem_select_n && busy_n;
            wadr_q = addr;
            wdat_q = data_out;
        end
    end

    // Near port writes land at the end of the strobe
    always @(posedge rw_n) begin
        if (wtok_q)
            tok_wr(1, int'(wadr_q[2:0]), wdat_q[0]);
        else if (wmem_q)
            mem[wadr_q[3:0]] = wdat_q;
    end

    // Far port token traffic, ties fall to one side
    always @(posedge pclk) begin
        if (oth_req === 1'b1) tok_wr(2, oth_idx, oth_val);
    end

    // Read value latched when the output opens
    always @(negedge oe_n) begin
        if (!token_select_low) rd_q = (own[addr[2:0]] != 2'h1);
    end

    // Released pins show the inverse of the last value
    always @(posedge pclk) begin
        if (!oe_n) last_q <= data_in;
    end

    // Read data, flag and ownership view
    always_comb begin
        if (!oe_n && rw_n && !token_select_low)
            data_in = {DW{rd_q}};
        else if (!oe_n && rw_n && !mem_select_n) data_in = mem[addr[3:0]];
        else data_in = ~last_q;
        for (int i = 0; i < 8; i++) mine[i] = (own[i] == 2'h1);
    end
    assign busy_n = !(role_master && force_busy && !mem_select_n);
endmodule : dps_dev_model

// ---- dps_ctrl_test.sv ----
`timescale 1ns/1ps
// ------------------------------------------------
// Bench: APB master, device model, sequences
// ------------------------------------------------
module dps_ctrl_test;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, data_out, data_in, mine;
    logic [31:0] pwdata, prdata, rd;
    logic        mem_select_n, token_select_low, rw_n, oe_n, data_oe;
    logic        busy_n, role_master, force_busy, oth_req, oth_val, er;
    logic [14:0] addr;
    logic [2:0]  oth_idx;
    int          err_total, check_count;

    dps_ctrl #(.AW(15), .DW(8)) dps_ctrl_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_select_n(mem_select_n),
        .token_select_low(token_select_low), .rw_n(rw_n), .oe_n(oe_n),
        .addr(addr), .data_out(data_out), .data_oe(data_oe),
        .data_in(data_in), .busy_n(busy_n), .role_master(role_master));
    dps_dev_model #(.AW(15), .DW(8)) dps_dev_model_inst (.pclk(pclk),
        .mem_select_n(mem_select_n), .token_select_low(token_select_low),
        .rw_n(rw_n), .oe_n(oe_n), .addr(addr), .data_out(data_out),
        .data_in(data_in), .busy_n(busy_n), .role_master(role_master),
        .force_busy(force_busy), .oth_req(oth_req), .oth_val(oth_val),
        .oth_idx(oth_idx), .mine(mine));

    // Clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Compare and verdict
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task finish_test;
        $display("mismatches %0d, checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test

    // APB transfer, entered just after a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    function automatic logic [31:0] ctl(input logic [2:0] op,
        input logic st, input logic ab);
        return {22'h0, ab, st, 4'h0, 1'b1, op};
    endfunction : ctl
    task start(input logic [2:0] op, input logic [31:0] a,
        input logic [31:0] d);
        apb(1'b1, dps_pkg::ADDR_OFS, a);
        apb(1'b1, dps_pkg::WDATA_OFS, d);
        apb(1'b1, dps_pkg::CTRL_OFS, ctl(op, 1'b1, 1'b0));
    endtask : start
    task wait_done;
        do begin
            apb(1'b0, dps_pkg::STATUS_OFS, 32'h0);
        end while (rd[1] !== 1'b1);
    endtask : wait_done
    task run(input logic [2:0] op, input logic [31:0] a,
        input logic [31:0] d);
        start(op, a, d);
        wait_done();
    endtask : run
    task oth(input logic [2:0] i, input logic v);
        oth_idx <= i;
        oth_val <= v;
        oth_req <= 1'b1;
        @(posedge pclk);
        oth_req <= 1'b0;
    endtask : oth
    task owned(input logic [7:0] bm, input logic bit3);
        apb(1'b0, dps_pkg::STATUS_OFS, 32'h0);
        check({rd[15:8], rd[3]}, {23'h0, bm, bit3});
        check(mine, bm);
    endtask : owned

    // Watchdog
    initial begin
        repeat (60000) @(posedge pclk);
        err_total++;
        finish_test();
    end

    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, force_busy} = '0;
        {oth_req, oth_val, oth_idx, err_total, check_count} = '0;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, dps_pkg::STATUS_OFS, 32'h0);
        check(rd, 32'h8);
        apb(1'b0, 8'h14, 32'h0);
        check(er, 1'b1);
        check(role_master, 1'b0);
        apb(1'b1, dps_pkg::CTRL_OFS, ctl(3'h5, 1'b1, 1'b0));
        apb(1'b0, dps_pkg::STATUS_OFS, 32'h0);
        check(rd[1:0], 2'h0);
        run(dps_pkg::DPS_MEM_WR, 32'h12, 32'ha5);
        check(role_master, 1'b1);
        run(dps_pkg::DPS_MEM_RD, 32'h12, 32'h0);
        apb(1'b0, dps_pkg::RDATA_OFS, 32'h0);
        check(rd, 32'ha5);
        run(dps_pkg::DPS_TOK_ACQ, 32'h7ff3, 32'h0);
        owned(8'h08, 1'b0);
        oth(3'h5, 1'b0);
        start(dps_pkg::DPS_TOK_ACQ, 32'h5, 32'h0);
        repeat (60) @(posedge pclk);
        apb(1'b0, dps_pkg::STATUS_OFS, 32'h0);
        check(rd[1:0], 2'h1);
        oth(3'h5, 1'b1);
        run(dps_pkg::DPS_TOK_ACQ, 32'h5, 32'h0);
        owned(8'h28, 1'b0);
        run(dps_pkg::DPS_TOK_REL, 32'h3, 32'h0);
        run(dps_pkg::DPS_TOK_RD, 32'h3, 32'h0);
        owned(8'h20, 1'b1);
        apb(1'b0, dps_pkg::RDATA_OFS, 32'h0);
        check(rd, 32'hff);
        run(dps_pkg::DPS_TOK_RD, 32'h5, 32'h0);
        apb(1'b0, dps_pkg::RDATA_OFS, 32'h0);
        check(rd, 32'h0);
        force_busy <= 1'b1;
        start(dps_pkg::DPS_MEM_WR, 32'h4, 32'h3c);
        repeat (60) @(posedge pclk);
        apb(1'b0, dps_pkg::STATUS_OFS, 32'h0);
        check(rd[2:0], 3'b101);
        force_busy <= 1'b0;
        wait_done();
        run(dps_pkg::DPS_MEM_RD, 32'h4, 32'h0);
        apb(1'b0, dps_pkg::RDATA_OFS, 32'h0);
        check(rd, 32'h3c);
        oth(3'h3, 1'b0);
        start(dps_pkg::DPS_TOK_ACQ, 32'h3, 32'h0);
        repeat (40) @(posedge pclk);
        apb(1'b1, dps_pkg::CTRL_OFS, ctl(3'h2, 1'b0, 1'b1));
        repeat (40) @(posedge pclk);
        apb(1'b0, dps_pkg::STATUS_OFS, 32'h0);
        check(rd[0], 1'b0);
        owned(8'h20, 1'b1);
        finish_test();
    end
endmodule : dps_ctrl_test

bind dps_ctrl dps_ctrl_chk #(.AW(AW), .DW(DW)) dps_ctrl_chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_select_n(mem_select_n),
    .token_select_low(token_select_low), .rw_n(rw_n), .oe_n(oe_n),
    .addr(addr), .data_out(data_out), .data_oe(data_oe),
    .data_in(data_in), .busy_n(busy_n), .role_master(role_master));
